/* File: design/nbmp_host.sv */
// Host controller driving an asynchronous nonvolatile byte memory
// Functional notes
// - Strobe low at select fall means write
// - Write ends at first strobe rise
// - Host observes full cycle time
// - Select stays high for precharge time
// - Fresh select fall for every access
// - Select low no longer than maximum
// - Select held low for minimum active
`timescale 1ns/1ns
`include "nbmp_map.svh"
module nbmp_host #(
  parameter int ACCESS_CYC = `NBMP_CEIL_CYC(`NBMP_ACCESS_NS),
  parameter int PRE_CYC    = `NBMP_CEIL_CYC(`NBMP_PRECHARGE_NS),
  parameter int CYCLE_CYC  = `NBMP_CEIL_CYC(`NBMP_CYCLE_NS),
  parameter int MAX_CYC    = `NBMP_FLOOR_CYC(`NBMP_SELECT_MAX_NS)
) (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     req_write,
  input  wire logic [`NBMP_ADDR_W-1:0]  req_addr,
  input  wire logic [`NBMP_DATA_W-1:0]  req_wdata,
  output logic                          rsp_valid,
  output logic      [`NBMP_DATA_W-1:0]  rsp_rdata,
  output logic      [`NBMP_ADDR_W-1:0]  mem_addr,
  output logic                          mem_select_n,
  output logic                          mem_write_n,
  output logic                          mem_oe_n,
  input  wire logic [`NBMP_DATA_W-1:0]  mem_dq_i,
  output logic      [`NBMP_DATA_W-1:0]  mem_dq_o,
  output logic                          mem_dq_oe
);
  // Active phase length: at least access time and cycle minus precharge
  localparam int ACT_CYC = (CYCLE_CYC - PRE_CYC > ACCESS_CYC) ? CYCLE_CYC - PRE_CYC : ACCESS_CYC;
  localparam int CNT_W   = 8;

  nbmp_pkg::nbmp_state_t            state_reg, state_next;  // Sequencer state
  logic [CNT_W-1:0]                 cnt_reg, cnt_next;      // Phase counter
  logic                             wr_reg, wr_next;        // Cycle is a write
  logic [`NBMP_ADDR_W-1:0]          addr_reg, addr_next;    // Pin address
  logic [`NBMP_DATA_W-1:0]          wdat_reg, wdat_next;    // Write data
  logic [`NBMP_DATA_W-1:0]          rdat_reg, rdat_next;    // Read result
  logic                             rsp_reg, rsp_next;      // Read done pulse

  // Ready only when idle, after precharge is over
  assign req_ready    = (state_reg == nbmp_pkg::NBMP_IDLE);
  assign mem_addr     = addr_reg;
  assign mem_select_n = (state_reg != nbmp_pkg::NBMP_ACTIVE);
  // Select-controlled write: strobe low from select fall to select rise
  assign mem_write_n  = !(state_reg == nbmp_pkg::NBMP_ACTIVE && wr_reg);
  // Output enable asserted only during reads
  assign mem_oe_n     = !(state_reg == nbmp_pkg::NBMP_ACTIVE && !wr_reg);
  assign mem_dq_o     = wdat_reg;
  assign mem_dq_oe    = (state_reg == nbmp_pkg::NBMP_ACTIVE) && wr_reg;
  assign rsp_valid    = rsp_reg;
  assign rsp_rdata    = rdat_reg;

  // Next-state logic of the access sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rdat_next  = rdat_reg;
    rsp_next   = 1'b0;
    case (state_reg)
      nbmp_pkg::NBMP_IDLE: begin
        // Accept one request, start with a fresh select fall
        if (req_valid) begin
          state_next = nbmp_pkg::NBMP_ACTIVE;
          wr_next    = req_write;
          addr_next  = req_addr;
          wdat_next  = req_wdata;
          cnt_next   = CNT_W'(ACT_CYC - 1);
        end
      end
      nbmp_pkg::NBMP_ACTIVE: begin
        // Hold select low for the active time; max only checked by an assertion
        if (cnt_reg == '0) begin
          state_next = nbmp_pkg::NBMP_PRECHARGE;
          cnt_next   = CNT_W'(PRE_CYC - 1);
          if (!wr_reg) begin
            rdat_next = mem_dq_i;
            rsp_next  = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      nbmp_pkg::NBMP_PRECHARGE: begin
        // Keep select high for precharge before next access
        if (cnt_reg == '0) begin
          state_next = nbmp_pkg::NBMP_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = nbmp_pkg::NBMP_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= nbmp_pkg::NBMP_IDLE;
      cnt_reg   <= '0;
      wr_reg    <= 1'b0;
      addr_reg  <= '0;
      wdat_reg  <= '0;
      rdat_reg  <= '0;
      rsp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rdat_reg  <= rdat_next;
      rsp_reg   <= rsp_next;
    end
  end

  // Helper: length of current select-low and select-high runs
  logic [CNT_W-1:0] low_run_reg, low_run_next;    // Cycles with select low
  logic [CNT_W-1:0] high_run_reg, high_run_next;  // Cycles with select high

  // Next values of the run counters
  always_comb begin
    low_run_next  = mem_select_n ? '0 : low_run_reg + 1'b1;
    high_run_next = '0;
    if (mem_select_n) begin
      // Saturate so a long idle gap never wraps to a short one
      high_run_next = (high_run_reg == '1) ? high_run_reg : high_run_reg + 1'b1;
    end
  end

  // Run counter registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_run_reg  <= '0;
      high_run_reg <= '0;
    end else begin
      low_run_reg  <= low_run_next;
      high_run_reg <= high_run_next;
    end
  end

  // Select low never beyond maximum active time
  a_select_max_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    low_run_reg <= CNT_W'(MAX_CYC)) else $error("select held low too long");
  // Select low lasts at least the access time
  a_select_min_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(mem_select_n) && $past(state_reg) == nbmp_pkg::NBMP_ACTIVE) |-> $past(low_run_reg) >= CNT_W'(ACCESS_CYC - 1))
    else $error("select low shorter than active time");
  // Precharge satisfied before next select fall
  a_precharge_min: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(mem_select_n) |-> high_run_reg >= CNT_W'(PRE_CYC))
    else $error("precharge too short");
  // Each request gives a fresh select fall within one cycle
  a_fresh_select: assert property (@(posedge sys_clk) disable iff (!resetn)
    (req_valid && req_ready) |=> $fell(mem_select_n)) else $error("no select fall for access");
  // Address stable while select is low
  a_addr_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!mem_select_n && !$past(mem_select_n)) |-> $stable(mem_addr)) else $error("address moved in cycle");
  // Host drives write data while strobe low, with select low, never with output enable
  a_write_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    !mem_write_n |-> (mem_dq_oe && mem_oe_n && !mem_select_n)) else $error("bad write pin state");
  // Read response follows a read cycle end
  a_read_resp: assert property (@(posedge sys_clk) disable iff (!resetn)
    rsp_valid |-> ($past(!mem_oe_n) && mem_select_n)) else $error("response without read");
  // Whole cycle spans at least the cycle time
  a_cycle_time: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(mem_select_n) |-> (!mem_select_n)[*2] ##1 (mem_select_n && !req_ready)[*2])
    else $error("cycle too short");
  // Output enable only in a selected read, never with host drive
  a_oe_read_only: assert property (@(posedge sys_clk) disable iff (!resetn)
    !mem_oe_n |-> (!mem_select_n && mem_write_n && !mem_dq_oe))
    else $error("output enable outside read");
  // Deselected pins stay quiet
  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    mem_select_n |-> (mem_write_n && mem_oe_n && !mem_dq_oe))
    else $error("pins active while deselected");
  // Strobe level fixed for the whole select-low phase
  a_strobe_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!mem_select_n && !$past(mem_select_n)) |-> $stable(mem_write_n))
    else $error("strobe moved in cycle");
  // Write data held until the strobe rises
  a_wdata_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!mem_write_n && !$past(mem_write_n)) |-> $stable(mem_dq_o))
    else $error("write data moved before strobe rise");
  // Read response is a single-cycle pulse
  a_rsp_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
  // No new request taken while a cycle runs
  a_ready_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(mem_select_n) |-> !req_ready) else $error("ready during active cycle");
  // Read data changes only with a response
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !rsp_valid |-> $stable(rsp_rdata)) else $error("read data moved without response");
  // Address held into precharge after select rise
  a_addr_precharge: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mem_select_n && !$past(mem_select_n)) |-> $stable(mem_addr))
    else $error("address moved at select rise");
endmodule : nbmp_host

/* File: design/nbmp_map.svh */
// Timing and geometry constants for the byte memory port host controller
`ifndef NBMP_MAP_SVH
`define NBMP_MAP_SVH
`define NBMP_CLK_PERIOD_NS  50
`define NBMP_ADDR_W         13
`define NBMP_DATA_W         8
`define NBMP_ACCESS_NS      70
`define NBMP_PRECHARGE_NS   60
`define NBMP_CYCLE_NS       130
`define NBMP_SELECT_MAX_NS  1000
`define NBMP_SETUP_NS       30
`define NBMP_CEIL_CYC(ns)   (((ns) + `NBMP_CLK_PERIOD_NS - 1) / `NBMP_CLK_PERIOD_NS)
`define NBMP_FLOOR_CYC(ns)  ((ns) / `NBMP_CLK_PERIOD_NS)
`endif

/* File: design/nbmp_pkg.sv */
// Types for the byte memory port host controller
package nbmp_pkg;
  typedef enum logic [2:0] {
    NBMP_IDLE,
    NBMP_ACTIVE,
    NBMP_PRECHARGE
  } nbmp_state_t;
endpackage : nbmp_pkg

/* File: verif/nbmp_dev_model.sv */
// Behavioural model of the nonvolatile byte memory behind the host controller
`timescale 1ns/1ns
module nbmp_dev_model #(
  parameter int PRECHARGE_MIN_TIME     = 60,
  parameter int SELECT_ACTIVE_MIN_TIME = 70
) (
  input  wire logic [12:0] addr,
  input  wire logic        select_n,
  input  wire logic        write_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  host_dq,
  input  wire logic        host_oe,
  output wire logic [7:0]  dq,
  output int               viol
);
  logic [7:0]  arr [8192];  // Byte array, rows of eight bytes
  logic [12:0] lat_addr;    // Address latched at select fall
  logic        wr_cyc;      // Cycle is a write
  logic        valid;       // Access time elapsed
  logic [7:0]  wbyte;       // Byte seen on bus during write
  logic [7:0]  last;        // Last byte driven, for release pattern
  time         t_fall;      // Last select fall
  time         t_rise;      // Last select rise
  // Preload a known pattern
  initial begin
    for (int i = 0; i < 8192; i++) arr[i] = i[7:0] ^ 8'ha5;
    viol = 0;
    t_rise = 0;
    t_fall = 0;
    wr_cyc = 1'b0;
    valid = 1'b0;
    last = 8'h00;
  end
  // Latch address and cycle type, check precharge
  always @(negedge select_n) begin
    lat_addr = addr;
    wr_cyc = !write_n;
    valid = 1'b0;
    valid <= #70 1'b1;
    if ($time - t_rise < PRECHARGE_MIN_TIME) viol++;
    t_fall = $time;
  end
  // Strobe falling mid-cycle turns it into a write
  always @(negedge write_n) if (!select_n) wr_cyc = 1'b1;
  // Track the byte on the bus while writing
  always @* if (!select_n && wr_cyc && !write_n) wbyte = host_oe ? host_dq : ~last;
  // Store at first strobe or select rise, no busy time
  always @(posedge select_n or posedge write_n) if (wr_cyc) arr[lat_addr] = wbyte;
  // Check select low time
  always @(posedge select_n) begin
    t_rise = $time;
    if (t_fall > 0 && ($time - t_fall < SELECT_ACTIVE_MIN_TIME || $time - t_fall > 1000)) viol++;
  end
  // Drive only valid read data; released bus shows inverse of last
  wire drv = !select_n && !wr_cyc && !oe_n && valid;
  always @* if (drv) last = arr[lat_addr];
  assign dq = host_oe ? host_dq : (drv ? arr[lat_addr] : ~last);
endmodule : nbmp_dev_model

/* File: verif/tb.sv */
// Self-checking testbench for the byte memory port host controller
`timescale 1ns/1ns
`include "nbmp_map.svh"
module tb;
  logic                    sys_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    req_valid = 1'b0;
  logic                    req_write = 1'b0;
  logic [`NBMP_ADDR_W-1:0] req_addr = '0;
  logic [`NBMP_DATA_W-1:0] req_wdata = '0;
  logic                    req_ready, rsp_valid, mem_select_n, mem_write_n, mem_oe_n, mem_dq_oe;
  logic [`NBMP_DATA_W-1:0] rsp_rdata, mem_dq_i, mem_dq_o, q;
  logic [`NBMP_ADDR_W-1:0] mem_addr;
  logic [12:0]             tab [4] = '{13'h0000, 13'h0007, 13'h0008, 13'h1fff};
  int                      fail_count = 0;
  int                      checked = 0;
  int                      viol;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  nbmp_host dut (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_select_n(mem_select_n), .mem_write_n(mem_write_n),
    .mem_oe_n(mem_oe_n), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
  nbmp_dev_model dev (.addr(mem_addr), .select_n(mem_select_n), .write_n(mem_write_n), .oe_n(mem_oe_n),
    .host_dq(mem_dq_o), .host_oe(mem_dq_oe), .dq(mem_dq_i), .viol(viol));
  // Compare and count
  task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Print counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // One request; address scrambled after taking; latency checked
  task automatic access(logic wr, logic [12:0] a, logic [7:0] d, output logic [7:0] rd);
    int n;
    @(posedge sys_clk);
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    req_addr <= ~a;
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((wr ? req_ready : rsp_valid) !== 1'b1 && n < 20);
    rd = rsp_rdata;
    chk(wr ? "write turnaround" : "read latency", wr ? 13'h0005 : 13'h0003, 13'(n));
    if (n >= 20) summarize();
  endtask : access
  // Writes at row and range boundaries, then read back
  task automatic write_read_test();
    foreach (tab[i]) access(1'b1, tab[i], tab[i][7:0] ^ 8'h3c, q);
    foreach (tab[i]) begin
      access(1'b0, tab[i], 8'h00, q);
      chk("read back", {5'h00, tab[i][7:0] ^ 8'h3c}, {5'h00, q});
    end
    $display("test write_read done");
  endtask : write_read_test
  // Unwritten location twice in a row
  task automatic preload_test();
    repeat (2) begin
      access(1'b0, 13'h0064, 8'h00, q);
      chk("preload read", 13'h00c1, {5'h00, q});
    end
    $display("test preload done");
  endtask : preload_test
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    chk("idle pins", 13'h001d, {8'h00, mem_select_n, mem_write_n, mem_oe_n, mem_dq_oe, req_ready});
    resetn <= 1'b1;
    $display("test reset done");
    write_read_test();
    preload_test();
    chk("device timing violations", 13'h0000, 13'(viol));
    summarize();
  end
endmodule : tb
